// ### lds_buf2.sv
// two-entry valid/ready buffer built from flip-flops
module lds_buf2 #(
  parameter int W = 6,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0] mem_q [DEPTH]; // storage
  logic [AW-1:0] wp_q;         // write index
  logic [AW-1:0] rp_q;         // read index
  logic [AW:0] cnt_q;          // entries held
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  // index advance with wrap
  function automatic logic [AW-1:0] adv(input logic [AW-1:0] p);
    adv = (p == LAST) ? '0 : p + 1'b1;
  endfunction

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];

  // next fill level
  always_comb begin
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // indices, level and registered ready
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wp_q <= adv(wp_q);
      end
      if (pop) begin
        rp_q <= adv(rp_q);
      end
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != FULL);
    end
  end

  // data store
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
endmodule

// ### lds_core.sv
// dac source selection, power-up sequencing and two-wire slave port
// Functional notes
// - channel one: adc, row index, or direct byte
// - channel two selects its source identically
// - one adc result, channels otherwise independent
// - direct bytes come from registers four, five
// - each channel has its own direction bit
// - two-bit full scale setting per channel
// - 00 external, 01 low, 10 mid, 11 high
// - recall control bits, then power analog
// - adc enabled later; four equal results select
// - dac inputs zero during power-up sequence
// - filter disabled: single conversion is enough
// - direct selects apply to first selection
// - slave only; master starts and clocks
// - sda change with scl high: start/stop
// - sda released at power up
// - ignore bus until a start is seen
// - stop ends transfer; standby after read
// - release after eight bits; ninth acknowledges
// - address ack only on type and pins match
// - write bytes acknowledged, except listed cases
// - read: send, sample ack, continue or stop
// - no ack without latch except at 86, or after 80/85/86
// - latch cleared at power, set 80h, cleared 00h
// - bytes travel most significant bit first
module lds_core
  import lds_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // two-wire pins
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic [2:0] ADDR_SEL,
  // supply monitors
  input wire logic POR_OK,
  input wire logic ADC_SUPPLY_OK,
  // nonvolatile copy of the control bits
  input wire lds_pkg::lds_ctrl_t NV_CTRL,
  // adc conversions
  input wire logic ADC_VALID,
  input wire logic [5:0] ADC_RESULT,
  output logic ADC_READY,
  output logic ADC_EN,
  // look-up tables
  output logic [5:0] TBL1_ROW,
  input wire logic [7:0] TBL1_DATA,
  output logic [5:0] TBL2_ROW,
  input wire logic [7:0] TBL2_DATA,
  // analog side
  output logic ANALOG_EN,
  output lds_pkg::lds_chan_t CHAN1,
  output lds_pkg::lds_chan_t CHAN2,
  output logic [5:0] ADC_HELD,
  output logic STANDBY
);
  import lds_pkg::*;

  // power-up sequence states
  typedef enum logic [4:0] {
    PW_RECALL = 5'b00001,
    PW_ANALOG = 5'b00010,
    PW_ADCWAIT = 5'b00100,
    PW_FIRST = 5'b01000,
    PW_RUN = 5'b10000
  } lds_pw_t;

  // serial port states
  typedef enum logic [6:0] {
    SI_IDLE = 7'b0000001,
    SI_DEV = 7'b0000010,
    SI_WADDR = 7'b0000100,
    SI_WDATA = 7'b0001000,
    SI_ACKO = 7'b0010000,
    SI_RDATA = 7'b0100000,
    SI_ACKI = 7'b1000000
  } lds_si_t;

  lds_pw_t pw_q;            // power sequence state
  lds_si_t si_q;            // serial state
  lds_si_t nxt_q;           // state after the device acknowledge
  lds_ctrl_t ctrl_q;        // working control bits
  logic wel_q;              // write enable latch
  logic scl_m, scl_s, scl_p; // scl synchroniser and history
  logic sda_m, sda_s, sda_p; // sda synchroniser and history
  logic [2:0] adr_m, adr_s; // address pin synchroniser
  logic por_m, por_s;       // supply monitor synchronisers
  logic aok_m, aok_s;
  logic scl_rise, scl_fall, start, stop;
  logic [7:0] sh_q;         // receive shift register
  logic [7:0] tx_q;         // transmit shift register
  logic [3:0] bcnt_q;       // bit counter
  logic [7:0] ptr_q;        // byte address pointer
  logic lock_q;             // later data bytes refused
  logic mack_q;             // master acknowledged last read byte
  logic rw_q;               // current transfer is a read
  logic byte_done;          // eighth bit taken, scl now low
  logic ack_ok;             // data byte may be acknowledged
  logic wr_fire;            // accepted data byte write
  logic bv, br;             // buffer drain handshake
  logic [5:0] bdata;
  logic take;               // conversion taken by the filter
  logic [5:0] last_q;       // previous conversion
  logic have_q;             // previous conversion exists
  logic [2:0] mcnt_q, mcnt_d; // equal conversions in a row
  logic [5:0] held_q;       // held adc result
  logic held_v_q;           // held result valid
  logic tbl_ok_q;           // table data follows the current row
  logic no_adc;             // neither channel needs the adc

  // one-hot decode of the full scale setting
  function automatic logic [3:0] fs_dec(input logic [1:0] c);
    unique case (c)
      LDS_FS_EXT: fs_dec = 4'h1;
      LDS_FS_LOW: fs_dec = 4'h2;
      LDS_FS_MID: fs_dec = 4'h4;
      LDS_FS_HIGH: fs_dec = 4'h8;
    endcase
  endfunction

  // readback of a register byte
  function automatic logic [7:0] rd_byte(input logic [7:0] a,
      input lds_ctrl_t c, input logic write_enable_latch, input logic [5:0] adc);
    unique case (a)
      LDS_REG0_OFS: rd_byte = {1'b0, c.filt_off, c.fs2, c.fs1, c.dir2,
                               c.dir1};
      LDS_REG1_OFS: rd_byte = {c.lsel1, 1'b0, c.row1};
      LDS_REG2_OFS: rd_byte = {c.lsel2, 1'b0, c.row2};
      LDS_REG3_OFS: rd_byte = {6'h00, c.dsel2, c.dsel1};
      LDS_REG4_OFS: rd_byte = c.byte1;
      LDS_REG5_OFS: rd_byte = c.byte2;
      LDS_REG6_OFS: rd_byte = {write_enable_latch, 7'h00};
      LDS_STAT_OFS: rd_byte = {2'h0, adc};
      default: rd_byte = 8'h00;
    endcase
  endfunction

  // pin synchronisers; first stages feed only second stages
  always_ff @(posedge CLK) begin
    if (RST) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
      adr_m <= 3'h0;
      adr_s <= 3'h0;
      por_m <= 1'b0;
      por_s <= 1'b0;
      aok_m <= 1'b0;
      aok_s <= 1'b0;
    end else begin
      scl_m <= SCL;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= SDA_I;
      sda_s <= sda_m;
      sda_p <= sda_s;
      adr_m <= ADDR_SEL;
      adr_s <= adr_m;
      por_m <= POR_OK;
      por_s <= por_m;
      aok_m <= ADC_SUPPLY_OK;
      aok_s <= aok_m;
    end
  end

  // bus events and byte decisions
  always_comb begin
    scl_rise = scl_s & ~scl_p;
    scl_fall = ~scl_s & scl_p;
    start = scl_s & scl_p & sda_p & ~sda_s;
    stop = scl_s & scl_p & ~sda_p & sda_s;
    byte_done = scl_fall & (bcnt_q == LDS_BYTE_BITS);
    ack_ok = (wel_q | (ptr_q == LDS_REG6_OFS)) & ~lock_q;
    wr_fire = (si_q == SI_WDATA) & byte_done & ack_ok & ~start & ~stop;
  end

  // serial slave: responds only, never starts a transfer
  always_ff @(posedge CLK) begin
    if (RST) begin
      si_q <= SI_IDLE;
      nxt_q <= SI_IDLE;
      sh_q <= 8'h00;
      tx_q <= 8'hff;
      bcnt_q <= 4'h0;
      ptr_q <= 8'h00;
      lock_q <= 1'b0;
      mack_q <= 1'b0;
      rw_q <= 1'b0;
      STANDBY <= 1'b0;
    end else if (start) begin
      // any start, also a repeated one, opens an address byte
      si_q <= SI_DEV;
      bcnt_q <= 4'h0;
      lock_q <= 1'b0;
      STANDBY <= 1'b0;
    end else if (stop) begin
      si_q <= SI_IDLE;
      STANDBY <= rw_q;
      rw_q <= 1'b0;
    end else begin
      unique case (si_q)
        SI_IDLE: begin
          // wait for a start, ignore all else
          si_q <= SI_IDLE;
        end
        SI_DEV, SI_WADDR, SI_WDATA: begin
          if (scl_rise && bcnt_q != LDS_BYTE_BITS) begin
            sh_q <= {sh_q[6:0], sda_s};
            bcnt_q <= bcnt_q + 4'h1;
          end else if (byte_done) begin
            bcnt_q <= 4'h0;
            if (si_q == SI_DEV) begin
              // type and pin levels must match
              if (sh_q[7:4] == LDS_DEV_TYPE && sh_q[3:1] == adr_s) begin
                si_q <= SI_ACKO;
                rw_q <= sh_q[0];
                nxt_q <= sh_q[0] ? SI_RDATA : SI_WADDR;
              end else begin
                si_q <= SI_IDLE;
              end
            end else if (si_q == SI_WADDR) begin
              ptr_q <= sh_q;
              si_q <= SI_ACKO;
              nxt_q <= SI_WDATA;
            end else begin
              // data byte: acknowledged unless refused
              if (ptr_q == LDS_REG0_OFS || ptr_q == LDS_REG5_OFS ||
                  ptr_q == LDS_REG6_OFS) begin
                lock_q <= 1'b1;
              end
              ptr_q <= ptr_q + 8'h01;
              si_q <= ack_ok ? SI_ACKO : SI_IDLE;
              nxt_q <= SI_WDATA;
            end
          end
        end
        SI_ACKO: begin
          // acknowledge bit driven for the ninth clock
          if (scl_fall) begin
            si_q <= nxt_q;
            bcnt_q <= 4'h0;
            if (nxt_q == SI_RDATA) begin
              tx_q <= rd_byte(ptr_q, ctrl_q, wel_q, held_q);
              ptr_q <= ptr_q + 8'h01;
            end
          end
        end
        SI_RDATA: begin
          // next bit presented after each falling scl
          if (scl_fall) begin
            if (bcnt_q == LDS_LAST_TX_BIT) begin
              si_q <= SI_ACKI;
            end else begin
              tx_q <= {tx_q[6:0], 1'b1};
              bcnt_q <= bcnt_q + 4'h1;
            end
          end
        end
        SI_ACKI: begin
          if (scl_rise) begin
            mack_q <= ~sda_s;
          end
          if (scl_fall) begin
            if (mack_q) begin
              tx_q <= rd_byte(ptr_q, ctrl_q, wel_q, held_q);
              ptr_q <= ptr_q + 8'h01;
              bcnt_q <= 4'h0;
              si_q <= SI_RDATA;
            end else begin
              si_q <= SI_IDLE;
            end
          end
        end
        default: begin
          si_q <= SI_IDLE;
        end
      endcase
    end
  end

  // open-drain data pin, released from reset on
  always_ff @(posedge CLK) begin
    if (RST) begin
      SDA_O <= 1'b0;
      SDA_OE <= 1'b0;
    end else begin
      SDA_O <= 1'b0;
      SDA_OE <= (si_q == SI_ACKO) |
          ((si_q == SI_RDATA) & ~tx_q[7]);
    end
  end

  // working control bits: recall first, then serial writes
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_q <= LDS_CTRL_RST;
    end else if (pw_q == PW_RECALL) begin
      if (por_s) begin
        ctrl_q <= NV_CTRL;
      end
    end else if (wr_fire) begin
      unique case (ptr_q)
        LDS_REG0_OFS: begin
          ctrl_q.dir1 <= sh_q[LDS_R0_DIR1];
          ctrl_q.dir2 <= sh_q[LDS_R0_DIR2];
          ctrl_q.fs1 <= sh_q[LDS_R0_FS1 +: 2];
          ctrl_q.fs2 <= sh_q[LDS_R0_FS2 +: 2];
          ctrl_q.filt_off <= sh_q[LDS_R0_FILT];
        end
        LDS_REG1_OFS: begin
          ctrl_q.row1 <= sh_q[5:0];
          ctrl_q.lsel1 <= sh_q[LDS_RX_LSEL];
        end
        LDS_REG2_OFS: begin
          ctrl_q.row2 <= sh_q[5:0];
          ctrl_q.lsel2 <= sh_q[LDS_RX_LSEL];
        end
        LDS_REG3_OFS: begin
          ctrl_q.dsel1 <= sh_q[LDS_R3_DSEL1];
          ctrl_q.dsel2 <= sh_q[LDS_R3_DSEL2];
        end
        LDS_REG4_OFS: ctrl_q.byte1 <= sh_q;
        LDS_REG5_OFS: ctrl_q.byte2 <= sh_q;
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // write enable latch, cleared at every power up
  always_ff @(posedge CLK) begin
    if (RST || pw_q == PW_RECALL) begin
      wel_q <= 1'b0;
    end else if (wr_fire && ptr_q == LDS_REG6_OFS) begin
      if (sh_q == LDS_WEL_SET) begin
        wel_q <= 1'b1;
      end else if (sh_q == LDS_WEL_CLR) begin
        wel_q <= 1'b0;
      end
    end
  end

  // conversion buffer; drain stalls until the adc is enabled
  lds_buf2 #(.W(6), .DEPTH(2)) u_buf (
    .clk(CLK),
    .rst(RST),
    .in_valid(ADC_VALID),
    .in_data(ADC_RESULT),
    .in_ready(ADC_READY),
    .out_valid(bv),
    .out_data(bdata),
    .out_ready(br)
  );

  // repeat-match filter on the shared conversion stream
  always_comb begin
    br = (pw_q == PW_FIRST) | (pw_q == PW_RUN);
    take = bv & br;
    if (have_q && bdata == last_q) begin
      mcnt_d = (mcnt_q == LDS_MATCH_COUNT) ? mcnt_q : mcnt_q + 3'h1;
    end else begin
      mcnt_d = 3'h1;
    end
    no_adc = (ctrl_q.dsel1 | ctrl_q.lsel1) & (ctrl_q.dsel2 | ctrl_q.lsel2);
  end

  // held result updates after four matches, or each one unfiltered
  always_ff @(posedge CLK) begin
    if (RST || pw_q == PW_RECALL) begin
      last_q <= 6'h00;
      have_q <= 1'b0;
      mcnt_q <= 3'h0;
      held_q <= 6'h00;
      held_v_q <= 1'b0;
    end else if (take) begin
      last_q <= bdata;
      have_q <= 1'b1;
      mcnt_q <= mcnt_d;
      if (ctrl_q.filt_off || mcnt_d == LDS_MATCH_COUNT) begin
        held_q <= bdata;
        held_v_q <= 1'b1;
      end
    end
  end

  // power-up sequence; a supply drop restarts it
  always_ff @(posedge CLK) begin
    if (RST || !por_s) begin
      pw_q <= PW_RECALL;
    end else begin
      unique case (pw_q)
        PW_RECALL: pw_q <= PW_ANALOG;
        PW_ANALOG: pw_q <= PW_ADCWAIT;
        PW_ADCWAIT: if (aok_s) pw_q <= PW_FIRST;
        PW_FIRST: if (held_v_q || no_adc) pw_q <= PW_RUN;
        PW_RUN: pw_q <= PW_RUN;
        default: pw_q <= PW_RECALL;
      endcase
    end
  end

  // enables follow the sequence state
  always_ff @(posedge CLK) begin
    if (RST) begin
      ANALOG_EN <= 1'b0;
      ADC_EN <= 1'b0;
      ADC_HELD <= 6'h00;
    end else begin
      ANALOG_EN <= (pw_q != PW_RECALL);
      ADC_EN <= br;
      ADC_HELD <= held_q;
    end
  end

  // table rows: own row index or the shared adc result
  always_ff @(posedge CLK) begin
    if (RST) begin
      TBL1_ROW <= 6'h00;
      TBL2_ROW <= 6'h00;
      tbl_ok_q <= 1'b0;
    end else begin
      TBL1_ROW <= ctrl_q.lsel1 ? ctrl_q.row1 : held_q;
      TBL2_ROW <= ctrl_q.lsel2 ? ctrl_q.row2 : held_q;
      tbl_ok_q <= (pw_q == PW_RUN);
    end
  end

  // dac inputs, zero until the first selection is made
  always_ff @(posedge CLK) begin
    if (RST) begin
      CHAN1 <= '0;
      CHAN2 <= '0;
    end else begin
      CHAN1.dir <= ctrl_q.dir1;
      CHAN2.dir <= ctrl_q.dir2;
      CHAN1.fs <= fs_dec(ctrl_q.fs1);
      CHAN2.fs <= fs_dec(ctrl_q.fs2);
      if (pw_q == PW_RUN && tbl_ok_q) begin
        CHAN1.dac <= ctrl_q.dsel1 ? ctrl_q.byte1 : TBL1_DATA;
        CHAN2.dac <= ctrl_q.dsel2 ? ctrl_q.byte2 : TBL2_DATA;
      end else begin
        CHAN1.dac <= 8'h00;
        CHAN2.dac <= 8'h00;
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  dac_zero_a: assert property (pw_q != PW_RUN |=>
      CHAN1.dac == 8'h00 && CHAN2.dac == 8'h00)
      else $error("dac input not zero in power-up");
  dac1_src_a: assert property (pw_q == PW_RUN && tbl_ok_q |=>
      CHAN1.dac == ($past(ctrl_q.dsel1) ? $past(ctrl_q.byte1)
      : $past(TBL1_DATA))) else $error("channel one source wrong");
  dac2_src_a: assert property (pw_q == PW_RUN && tbl_ok_q |=>
      CHAN2.dac == ($past(ctrl_q.dsel2) ? $past(ctrl_q.byte2)
      : $past(TBL2_DATA))) else $error("channel two source wrong");
  row_shared_a: assert property (!ctrl_q.lsel2 |=>
      TBL2_ROW == $past(held_q)) else $error("table two row not adc");
  fs_decode_a: assert property (ctrl_q.fs1 == LDS_FS_MID |=>
      CHAN1.fs == 4'h4) else $error("full scale decode wrong");
  power_order_a: assert property ($rose(ANALOG_EN) |->
      $past(pw_q) == PW_ANALOG) else $error("analog up before recall");
  filter_hold_a: assert property (take && !ctrl_q.filt_off &&
      mcnt_d != LDS_MATCH_COUNT |=> $stable(held_q))
      else $error("held result changed early");
  single_conv_a: assert property (take && ctrl_q.filt_off |=>
      held_q == $past(bdata)) else $error("unfiltered result not held");
  wel_clear_a: assert property (wr_fire && ptr_q == LDS_REG6_OFS &&
      sh_q == LDS_WEL_CLR |=> !wel_q) else $error("latch not cleared");
  nack_wel_a: assert property (si_q == SI_WDATA && byte_done &&
      !start && !stop && !wel_q && ptr_q != LDS_REG6_OFS |=>
      si_q == SI_IDLE)
      else $error("data byte acked without latch");
  dev_match_a: assert property (si_q == SI_DEV && byte_done &&
      !start && !stop && sh_q[7:4] != LDS_DEV_TYPE |=> si_q == SI_IDLE)
      else $error("wrong type acknowledged");
  ack_drive_a: assert property (si_q == SI_ACKO &&
      $past(si_q) == SI_ACKO |-> SDA_OE && !SDA_O)
      else $error("acknowledge not driven");
  read_nack_a: assert property (si_q == SI_ACKI && scl_fall &&
      !start && !stop && !mack_q |=> si_q == SI_IDLE ##1 !SDA_OE)
      else $error("read continued after no ack");
  idle_wait_a: assert property (si_q == SI_IDLE && !start |=>
      si_q == SI_IDLE) else $error("left idle without start");

  first_run_c: cover property ($rose(pw_q == PW_RUN));
  read_byte_c: cover property (si_q == SI_ACKI && scl_fall && mack_q);
  wel_set_c: cover property (wr_fire && sh_q == LDS_WEL_SET);
  filt_match_c: cover property (take && mcnt_d == LDS_MATCH_COUNT);
endmodule

// ### lds_core_tb.sv
// self-checking bench of the dual source control core
module lds_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import lds_pkg::*;
  logic clk, rst, scl, m_oe, sda_oe, por, aok, ar, an, stby, sda_o;
  logic aen, k, x;
  logic [2:0] pins; // address-select pin levels
  logic [5:0] r1, r2, held;
  logic [7:0] d, t1, t2; // t1, t2: table bytes of the presented rows
  lds_ctrl_t nv;
  lds_chan_t ch1, ch2;
  logic [5:0] seq [8]; // conversion stream
  int idx, cyc, fails, checked;
  wire sda = ~(sda_oe | m_oe); // pulled-up open drain
  assign t1 = {2'h1, r1}; // table one: row number in the low bits
  assign t2 = {2'h2, r2}; // table two: same, other top bits
  // the converter offers results only while enabled
  lds_core dut (.CLK(clk), .RST(rst), .SCL(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .ADDR_SEL(pins), .POR_OK(por),
    .ADC_SUPPLY_OK(aok), .NV_CTRL(nv), .ADC_VALID(aen),
    .ADC_RESULT(seq[idx]), .ADC_READY(ar), .ADC_EN(aen),
    .TBL1_ROW(r1), .TBL1_DATA(t1), .TBL2_ROW(r2),
    .TBL2_DATA(t2), .ANALOG_EN(an), .CHAN1(ch1),
    .CHAN2(ch2), .ADC_HELD(held), .STANDBY(stby));
  lds_master m (.clk(clk), .sda(sda), .scl(scl), .oe(m_oe));
  // 200 MHz clock
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // next conversion once taken
  always @(posedge clk)
    if (ar === 1'b1 && aen === 1'b1 && idx < 7) idx <= idx + 1;
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      test_done;
    end
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one byte write transfer
  task wr(input logic [7:0] a, input logic [7:0] v, output logic ak);
    m.start;
    m.byte_w(8'h56, x);
    chk({7'h0, x}, 8'h1);
    m.byte_w(a, x);
    m.byte_w(v, ak);
    m.stop;
    m.w(4);
  endtask
  // main sequence
  initial begin
    seq = '{6'h05, 6'h05, 6'h05, 6'h09, 6'h2a, 6'h2a, 6'h2a, 6'h2a};
    {idx, cyc, fails, checked} = '0;
    {rst, por, aok} = 3'h4;
    pins = 3'h3;
    nv = LDS_CTRL_RST;
    nv.byte2 = 8'h5a; // recalled, never written: read back later
    m.w(4);
    rst = 0;
    m.w(4);
    chk({6'h0, sda_o, sda_oe}, 8'h0);
    por = 1;
    m.w(12);
    chk({6'h0, an, aen}, 8'h2);
    chk(ch1.dac, 8'h0);
    aok = 1;
    m.w(100);
    chk({2'h0, held}, 8'h2a);
    chk(ch1.dac, 8'h6a);
    chk(ch2.dac, 8'haa);
    // wrong type, wrong pins, then pins moved to match
    for (int i = 0; i < 3; i++) begin
      pins = (i == 2) ? 3'h1 : 3'h3;
      m.start;
      m.byte_w(i ? 8'h52 : 8'h76, k);
      chk({7'h0, k}, {7'h0, i == 2});
      m.stop;
    end
    pins = 3'h3;
    wr(LDS_REG4_OFS, 8'h3c, k);
    chk({7'h0, k}, 8'h0);
    wr(LDS_REG6_OFS, LDS_WEL_SET, k);
    chk({7'h0, k}, 8'h1);
    m.start;
    m.byte_w(8'h56, x);
    m.byte_w(LDS_REG6_OFS, x);
    m.byte_w(LDS_WEL_SET, x);
    m.byte_w(LDS_WEL_SET, k);
    chk({7'h0, k}, 8'h0);
    m.stop;
    wr(LDS_REG4_OFS, 8'h3c, k);
    chk({7'h0, k}, 8'h1);
    wr(LDS_REG3_OFS, 8'h01, k);
    wr(LDS_REG2_OFS, 8'h85, k);
    chk(ch1.dac, 8'h3c);
    chk(ch2.dac, 8'h85);
    for (int c = 0; c < 4; c++) begin
      wr(LDS_REG0_OFS, {4'h0, c[1:0], 2'h1}, k);
      chk({4'h0, ch1.fs}, {4'h0, 4'h1 << c});
      chk({6'h0, ch1.dir, ch2.dir}, 8'h2);
    end
    chk({4'h0, ch2.fs}, 8'h1);
    m.start;
    m.byte_w(8'h56, x);
    m.byte_w(LDS_REG4_OFS, x);
    m.start;
    m.byte_w(8'h57, k);
    m.byte_r(1'b1, d);
    chk(d, 8'h3c);
    m.byte_r(1'b0, d);
    chk(d, 8'h5a);
    m.stop;
    chk({7'h0, stby}, 8'h1);
    test_done;
  end
endmodule

// ### lds_master.sv
// two-wire bus master model for the slave port
module lds_master (
  // clock and bus
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // bus idle: clock high, data released
  initial begin
    scl = 1;
    oe = 0;
  end
  // wait core cycles, then step off the edge
  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // data falls while clock high
  task start;
    oe = 0;
    w(8);
    scl = 1;
    w(8);
    oe = 1;
    w(8);
    scl = 0;
    w(8);
  endtask
  // data rises while clock high
  task stop;
    oe = 1;
    w(8);
    scl = 1;
    w(8);
    oe = 0;
    w(16);
  endtask
  // one bit: data moves only with clock low
  task bitx(input logic b, output logic r);
    oe = ~b;
    w(8);
    scl = 1;
    w(16);
    r = sda;
    scl = 0;
    w(8);
  endtask
  // send a byte, return the ack seen
  task byte_w(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  // take a byte, answer ack or not
  task byte_r(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(~mack, r);
  endtask
endmodule

// ### lds_pkg.sv
// shared constants and types of the dual current source control core
package lds_pkg;

  // device type code of the slave address (value is arbitrary)
  localparam logic [3:0] LDS_DEV_TYPE = 4'h5;

  // byte addresses of the control and status registers
  localparam logic [7:0] LDS_REG0_OFS = 8'h80; // direction, range, filter
  localparam logic [7:0] LDS_REG1_OFS = 8'h81; // table one row and select
  localparam logic [7:0] LDS_REG2_OFS = 8'h82; // table two row and select
  localparam logic [7:0] LDS_REG3_OFS = 8'h83; // direct byte selects
  localparam logic [7:0] LDS_REG4_OFS = 8'h84; // channel one direct byte
  localparam logic [7:0] LDS_REG5_OFS = 8'h85; // channel two direct byte
  localparam logic [7:0] LDS_REG6_OFS = 8'h86; // write enable latch
  localparam logic [7:0] LDS_STAT_OFS = 8'h87; // held adc result

  // field positions
  localparam int LDS_R0_DIR1 = 0;
  localparam int LDS_R0_DIR2 = 1;
  localparam int LDS_R0_FS1 = 2;   // two bits
  localparam int LDS_R0_FS2 = 4;   // two bits
  localparam int LDS_R0_FILT = 6;
  localparam int LDS_RX_LSEL = 7;  // row select bit of registers 1 and 2
  localparam int LDS_R3_DSEL1 = 0;
  localparam int LDS_R3_DSEL2 = 1;
  localparam int LDS_R6_WEL = 7;

  // write enable latch patterns
  localparam logic [7:0] LDS_WEL_SET = 8'h80;
  localparam logic [7:0] LDS_WEL_CLR = 8'h00;

  // counts
  localparam logic [2:0] LDS_MATCH_COUNT = 3'h4; // equal conversions needed
  localparam logic [3:0] LDS_BYTE_BITS = 4'h8;
  localparam logic [3:0] LDS_LAST_TX_BIT = 4'h7;

  // full scale decode codes
  localparam logic [1:0] LDS_FS_EXT = 2'h0;
  localparam logic [1:0] LDS_FS_LOW = 2'h1;
  localparam logic [1:0] LDS_FS_MID = 2'h2;
  localparam logic [1:0] LDS_FS_HIGH = 2'h3;

  // working control bits of both channels
  typedef struct packed {
    logic dir1;
    logic dir2;
    logic [1:0] fs1;
    logic [1:0] fs2;
    logic filt_off;
    logic [5:0] row1;
    logic lsel1;
    logic [5:0] row2;
    logic lsel2;
    logic dsel1;
    logic dsel2;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } lds_ctrl_t;

  // value after reset: all defaults zero
  localparam lds_ctrl_t LDS_CTRL_RST = '0;

  // drive of one current output
  typedef struct packed {
    logic [7:0] dac;    // dac input byte
    logic dir;          // 1 selects the other current direction
    logic [3:0] fs;     // one-hot {high, mid, low, external}
  } lds_chan_t;

endpackage
